// File: eeprom_link_chk.sv
// concurrent checks on the two-wire link between the controller and memory ends
`timescale 1ns/100ps
module eeprom_link_chk #(
  parameter logic [2:0] STRAP = 3'h5
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [1:0] unit;
  logic [7:0] shreg;
  logic       rd;
  wire        rise     = scl & ~scl_q;
  wire        start    = scl & scl_q & sda_q & ~sda;
  wire        stop     = scl & scl_q & ~sda_q & sda;
  wire        ack_slot = rise & (cnt == 4'h8);
  wire        addr_hit = (shreg[7:4] == eeprom_read_pkg::DEV_TYPE) & (shreg[3:1] == STRAP);

  // bit and unit position on the wire, re-based at every start or repeated start
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
      unit  <= 2'h0;
      shreg <= 8'h00;
      rd    <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt  <= 4'h0;
        unit <= 2'h0;
      end else if (ack_slot) begin
        cnt  <= 4'h0;
        unit <= (unit == 2'h3) ? unit : unit + 2'h1;
      end else if (rise) begin
        cnt   <= cnt + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
      if (rise && cnt == 4'h7 && unit == 2'h0) begin
        rd <= sda;
      end
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  property p_dev_change_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("memory moved data while clock high");

  property p_ack_dev_addr;
    ack_slot && unit == 2'h0 && addr_hit |-> !sda && dev_sda_oe;
  endproperty
  a_ack_dev_addr: assert property (p_ack_dev_addr) else $error("matching address not acknowledged");

  property p_no_ack_other;
    ack_slot && unit == 2'h0 && !addr_hit |-> sda ##1 !dev_sda_oe [*8];
  endproperty
  a_no_ack_other: assert property (p_no_ack_other) else $error("foreign address answered");

  property p_ack_word_addr;
    ack_slot && !rd && (unit == 2'h1 || unit == 2'h2) |-> !sda;
  endproperty
  a_ack_word_addr: assert property (p_ack_word_addr) else $error("word address byte not acknowledged");

  property p_free_host_ack;
    ack_slot && rd && unit != 2'h0 |-> !dev_sda_oe;
  endproperty
  a_free_host_ack: assert property (p_free_host_ack) else $error("memory held line in host ack slot");

  property p_quiet_rx;
    rise && cnt < 4'h8 && (unit == 2'h0 || !rd) |-> !dev_sda_oe;
  endproperty
  a_quiet_rx: assert property (p_quiet_rx) else $error("memory drove line while receiving");

  property p_nack_release;
    ack_slot && rd && unit != 2'h0 && sda |=> !dev_sda_oe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("memory kept sending after no ack");

  property p_stop_free;
    stop |-> !dev_sda_oe;
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("memory drove line at stop");

  property p_open_drain;
    !dev_sda_o && !host_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
endmodule // eeprom_link_chk

// File: eeprom_read_device.sv
// serial memory end: address load, current, random and sequential reads
`timescale 1ns/100ps
module eeprom_read_device #(
  parameter int ADDR_W = eeprom_read_pkg::WORD_ADDR_W
) (
  input  wire logic              MCLK_I,
  input  wire logic              RESET_I,
  input  wire logic              CHIP_SELECT_STRAP_HI_I,
  input  wire logic              CHIP_SELECT_STRAP_MID_I,
  input  wire logic              CHIP_SELECT_STRAP_LO_I,
  input  wire logic              FILL_WE_I,
  input  wire logic [ADDR_W-1:0] FILL_ADDR_I,
  input  wire logic [7:0]        FILL_DATA_I,
  output logic                   STANDBY_O,
  two_wire_if.dev                link
);

  typedef enum logic [5:0] {
    D_IDLE    = 6'h01,
    D_DEVADDR = 6'h02,
    D_ADDR_HI = 6'h04,
    D_ADDR_LO = 6'h08,
    D_WRDATA  = 6'h10,
    D_READ    = 6'h20
  } dev_state_e;

  localparam int MEM_DEPTH = 1 << ADDR_W;

  logic [7:0]        mem [MEM_DEPTH];

  dev_state_e        state;
  dev_state_e        next_state;
  dev_state_e        cur_state;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_cnt;
  logic [3:0]        cur_cnt;
  logic [7:0]        rx_shift;
  logic [7:0]        tx_shift;
  logic [7:0]        next_tx;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] next_ptr;
  logic [7:0]        addr_hi;
  logic [7:0]        next_hi;
  logic              rw;
  logic              next_rw;
  logic              ack_pend;
  logic              next_ack;
  logic              start_tog;
  logic              stop_mark;
  logic              start_seen;
  logic [2:0]        strap_meta;
  logic [2:0]        strap_sync;
  logic              dev_idle;
  logic [2:0]        sb_meta;
  logic [2:0]        sb_sync;

  wire               start_new  = start_tog ^ start_seen;
  wire  [7:0]        rx_byte    = {rx_shift[6:0], link.sda};
  wire               byte_done  = (cur_cnt == eeprom_read_pkg::BIT_LAST);
  wire               ack_slot   = (cur_cnt == eeprom_read_pkg::BIT_ACK);
  wire               host_ack   = ~link.sda;
  wire  [7:0]        mem_rd     = mem[ptr];
  wire  [ADDR_W-1:0] ptr_inc    = ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire               type_ok    = (rx_byte[7:4] == eeprom_read_pkg::DEV_TYPE);
  wire               dev_match  = type_ok && (rx_byte[3:1] == strap_sync);
  wire               drive_bit  = (state == D_READ) && (bit_cnt <= eeprom_read_pkg::BIT_LAST);

  // a start is picked up at the first rising clock, which also carries bit 7
  assign cur_state = start_new ? D_DEVADDR : state;
  assign cur_cnt   = start_new ? eeprom_read_pkg::BIT_FIRST : bit_cnt;

  // start and stop are data edges while the clock is high; the frame
  // timing guarantees these toggles are settled before the next clock edge
  always_ff @(negedge link.sda or posedge RESET_I) begin
    if (RESET_I) begin
      start_tog <= 1'b0;
    end else if (link.scl) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge link.sda or posedge RESET_I) begin
    if (RESET_I) begin
      stop_mark <= 1'b0;
    end else if (link.scl) begin
      stop_mark <= start_tog;
    end
  end

  // host-side fill port; only safe while the link is in standby
  always_ff @(posedge MCLK_I) begin
    if (FILL_WE_I) begin
      mem[FILL_ADDR_I] <= FILL_DATA_I;
    end
  end

  always_comb begin
    next_state = cur_state;
    next_tx    = tx_shift;
    next_ptr   = ptr;
    next_hi    = addr_hi;
    next_rw    = rw;
    next_ack   = 1'b0;
    case (cur_state)
      D_IDLE: begin
        next_state = D_IDLE;
      end
      D_DEVADDR: begin
        if (byte_done) begin
          next_rw  = rx_byte[0];
          next_ack = dev_match;
          if (!dev_match) begin
            next_state = D_IDLE;
          end
        end else if (ack_slot) begin
          if (rw == eeprom_read_pkg::DIR_READ) begin
            next_state = D_READ;
            next_tx    = mem_rd;
            next_ptr   = ptr_inc;
          end else begin
            next_state = D_ADDR_HI;
          end
        end
      end
      D_ADDR_HI: begin
        if (byte_done) begin
          next_hi  = rx_byte;
          next_ack = 1'b1;
        end else if (ack_slot) begin
          next_state = D_ADDR_LO;
        end
      end
      D_ADDR_LO: begin
        if (byte_done) begin
          next_ptr = ADDR_W'({addr_hi, rx_byte});
          next_ack = 1'b1;
        end else if (ack_slot) begin
          next_state = D_WRDATA;
        end
      end
      D_WRDATA: begin
        // data bytes are acknowledged and skipped; the array is not written here
        if (byte_done) begin
          next_ack = 1'b1;
          next_ptr = ptr_inc;
        end
      end
      D_READ: begin
        if (ack_slot) begin
          if (host_ack) begin
            next_tx  = mem_rd;
            next_ptr = ptr_inc;
          end else begin
            next_state = D_IDLE;
          end
        end else begin
          next_tx = {tx_shift[6:0], 1'b0};
        end
      end
      default: begin
        next_state = D_IDLE;
      end
    endcase
  end

  assign next_cnt = (ack_slot || cur_state == D_IDLE) ? eeprom_read_pkg::BIT_FIRST : cur_cnt + 4'h1;

  // rising clock: sample data and advance the byte sequencer
  always_ff @(posedge link.scl or posedge RESET_I) begin
    if (RESET_I) begin
      state      <= D_IDLE;
      bit_cnt    <= eeprom_read_pkg::BIT_FIRST;
      rx_shift   <= 8'h00;
      tx_shift   <= 8'h00;
      ptr        <= '0;
      addr_hi    <= 8'h00;
      rw         <= eeprom_read_pkg::DIR_WRITE;
      ack_pend   <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_cnt;
      rx_shift   <= rx_byte;
      tx_shift   <= next_tx;
      ptr        <= next_ptr;
      addr_hi    <= next_hi;
      rw         <= next_rw;
      ack_pend   <= next_ack;
      start_seen <= start_tog;
    end
  end

  // straps are pins; settle them before the address compare reads them
  always_ff @(posedge link.scl or posedge RESET_I) begin
    if (RESET_I) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      dev_idle   <= 1'b1;
    end else begin
      strap_meta <= {CHIP_SELECT_STRAP_HI_I, CHIP_SELECT_STRAP_MID_I, CHIP_SELECT_STRAP_LO_I};
      strap_sync <= strap_meta;
      dev_idle   <= (next_state == D_IDLE);
    end
  end

  // falling clock: data changes only while the clock is low
  always_ff @(negedge link.scl or posedge RESET_I) begin
    if (RESET_I) begin
      link.dev_sda_oe <= 1'b0;
      link.dev_sda_o  <= 1'b0;
    end else begin
      link.dev_sda_o  <= 1'b0;
      link.dev_sda_oe <= ack_pend || (drive_bit && !tx_shift[7]);
    end
  end

  // standby: stop seen since the last start, or not addressed
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sb_meta   <= 3'h0;
      sb_sync   <= 3'h0;
      STANDBY_O <= 1'b1;
    end else begin
      sb_meta   <= {start_tog, stop_mark, dev_idle};
      sb_sync   <= sb_meta;
      STANDBY_O <= (sb_sync[2] == sb_sync[1]) || sb_sync[0];
    end
  end

endmodule // eeprom_read_device

// File: eeprom_read_host.sv
// bus controller end: issues current-address, random and sequential reads
`timescale 1ns/100ps
module eeprom_read_host #(
  parameter int QTR_CYC = eeprom_read_pkg::QTR_CYC_DEF
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  input  wire logic        REQ_I,
  input  wire logic        RANDOM_I,
  input  wire logic [2:0]  CHIP_SEL_I,
  input  wire logic [15:0] WORD_ADDR_I,
  input  wire logic [7:0]  LEN_I,
  output logic             BUSY_O,
  output logic             NO_ACK_O,
  output logic [7:0]       RD_DATA_O,
  output logic             RD_VALID_O,
  two_wire_if.host         link
);

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_WBYTE = 5'h04,
    H_RBYTE = 5'h08,
    H_STOP  = 5'h10
  } host_state_e;

  host_state_e state;
  logic [$clog2(QTR_CYC+1)-1:0] qcnt;
  logic [1:0]  q;
  logic [1:0]  sel;
  logic [3:0]  bit_idx;
  logic [7:0]  shreg;
  logic [7:0]  left;
  logic [2:0]  cs;
  logic [15:0] waddr;
  logic        sda_meta;
  logic        sda_sync;

  wire         tick     = (qcnt == ($clog2(QTR_CYC+1))'(QTR_CYC - 1));
  wire         in_ack   = (bit_idx == eeprom_read_pkg::BIT_ACK);
  wire         last_bit = (bit_idx == eeprom_read_pkg::BIT_LAST);
  wire         more     = (left != eeprom_read_pkg::LEN_MIN);
  wire  [7:0]  dev_wr   = {eeprom_read_pkg::DEV_TYPE, cs, eeprom_read_pkg::DIR_WRITE};
  wire  [7:0]  dev_rd   = {eeprom_read_pkg::DEV_TYPE, cs, eeprom_read_pkg::DIR_READ};
  wire  [7:0]  wbyte    = (sel == eeprom_read_pkg::SEL_DEV_WR)  ? dev_wr :
                          (sel == eeprom_read_pkg::SEL_ADDR_HI) ? waddr[15:8] :
                          (sel == eeprom_read_pkg::SEL_ADDR_LO) ? waddr[7:0] : dev_rd;

  // the data line is a pin: two flops before anything reads it
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= link.sda;
      sda_sync <= sda_meta;
    end
  end

  // quarter-period divider makes the link clock; it rests high when idle
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      qcnt <= '0;
      q    <= eeprom_read_pkg::Q_SETUP;
    end else if (state == H_IDLE || tick) begin
      qcnt <= '0;
      q    <= (state == H_IDLE) ? eeprom_read_pkg::Q_SETUP : q + 2'h1;
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state            <= H_IDLE;
      link.scl         <= 1'b1;
      link.host_sda_o  <= 1'b0;
      link.host_sda_oe <= 1'b0;
      sel              <= eeprom_read_pkg::SEL_DEV_WR;
      bit_idx          <= eeprom_read_pkg::BIT_FIRST;
      shreg            <= 8'h00;
      left             <= eeprom_read_pkg::LEN_MIN;
      cs               <= 3'h0;
      waddr            <= 16'h0000;
      BUSY_O           <= 1'b0;
      NO_ACK_O         <= 1'b0;
      RD_DATA_O        <= 8'h00;
      RD_VALID_O       <= 1'b0;
    end else begin
      link.host_sda_o <= 1'b0;
      RD_VALID_O      <= 1'b0;
      case (state)
        H_IDLE: begin
          if (REQ_I) begin
            state    <= H_START;
            BUSY_O   <= 1'b1;
            NO_ACK_O <= 1'b0;
            cs       <= CHIP_SEL_I;
            waddr    <= WORD_ADDR_I;
            left     <= (LEN_I == 8'h00) ? eeprom_read_pkg::LEN_MIN : LEN_I;
            sel      <= RANDOM_I ? eeprom_read_pkg::SEL_DEV_WR : eeprom_read_pkg::SEL_DEV_RD;
          end
        end
        H_START: begin
          if (tick) begin
            case (q)
              eeprom_read_pkg::Q_SETUP:  link.host_sda_oe <= 1'b0;
              eeprom_read_pkg::Q_RISE:   link.scl         <= 1'b1;
              eeprom_read_pkg::Q_SAMPLE: link.host_sda_oe <= 1'b1;
              default: begin
                link.scl <= 1'b0;
                state    <= H_WBYTE;
                bit_idx  <= eeprom_read_pkg::BIT_FIRST;
                shreg    <= wbyte;
              end
            endcase
          end
        end
        H_WBYTE: begin
          if (tick) begin
            case (q)
              eeprom_read_pkg::Q_SETUP:  link.host_sda_oe <= !in_ack && !shreg[7];
              eeprom_read_pkg::Q_RISE:   link.scl         <= 1'b1;
              eeprom_read_pkg::Q_SAMPLE: shreg            <= in_ack ? shreg : {shreg[6:0], 1'b0};
              default: begin
                link.scl <= 1'b0;
                bit_idx  <= in_ack ? eeprom_read_pkg::BIT_FIRST : bit_idx + 4'h1;
                if (in_ack && sda_sync) begin
                  NO_ACK_O <= 1'b1;
                  state    <= H_STOP;
                end else if (in_ack && sel == eeprom_read_pkg::SEL_ADDR_LO) begin
                  sel   <= eeprom_read_pkg::SEL_DEV_RD;
                  state <= H_START;
                end else if (in_ack && sel == eeprom_read_pkg::SEL_DEV_RD) begin
                  state <= H_RBYTE;
                end else if (in_ack) begin
                  sel   <= sel + 2'h1;
                  shreg <= (sel == eeprom_read_pkg::SEL_DEV_WR) ? waddr[15:8] : waddr[7:0];
                end
              end
            endcase
          end
        end
        H_RBYTE: begin
          if (tick) begin
            case (q)
              eeprom_read_pkg::Q_SETUP:  link.host_sda_oe <= in_ack && more;
              eeprom_read_pkg::Q_RISE:   link.scl         <= 1'b1;
              eeprom_read_pkg::Q_SAMPLE: shreg            <= in_ack ? shreg : {shreg[6:0], sda_sync};
              default: begin
                link.scl <= 1'b0;
                bit_idx  <= in_ack ? eeprom_read_pkg::BIT_FIRST : bit_idx + 4'h1;
                if (last_bit) begin
                  RD_DATA_O  <= shreg;
                  RD_VALID_O <= 1'b1;
                end
                if (in_ack && more) begin
                  left <= left - 8'h01;
                end else if (in_ack) begin
                  state <= H_STOP;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            case (q)
              eeprom_read_pkg::Q_SETUP:  link.host_sda_oe <= 1'b1;
              eeprom_read_pkg::Q_RISE:   link.scl         <= 1'b1;
              eeprom_read_pkg::Q_SAMPLE: link.host_sda_oe <= 1'b0;
              default: begin
                state  <= H_IDLE;
                BUSY_O <= 1'b0;
              end
            endcase
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule // eeprom_read_host

// File: eeprom_read_pkg.sv
// shared constants for the two-wire serial memory read link
package eeprom_read_pkg;
  localparam int         WORD_ADDR_W = 16;
  localparam int         BYTE_W      = 8;
  localparam logic [3:0] DEV_TYPE    = 4'hA;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic       DIR_WRITE   = 1'b0;
  localparam logic [3:0] BIT_FIRST   = 4'h0;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [1:0] Q_SETUP     = 2'h0;
  localparam logic [1:0] Q_RISE      = 2'h1;
  localparam logic [1:0] Q_SAMPLE    = 2'h2;
  localparam logic [1:0] Q_FALL      = 2'h3;
  localparam int         QTR_CYC_DEF = 2;
  localparam logic [1:0] SEL_DEV_WR  = 2'h0;
  localparam logic [1:0] SEL_ADDR_HI = 2'h1;
  localparam logic [1:0] SEL_ADDR_LO = 2'h2;
  localparam logic [1:0] SEL_DEV_RD  = 2'h3;
  localparam logic [7:0] LEN_MIN     = 8'h01;
endpackage

// File: tb.sv
// self-checking bench: controller and memory ends joined over the two-wire link
`timescale 1ns/100ps
module tb;
  logic        mclk;
  logic        reset;
  logic        req;
  logic        random_rd;
  logic [2:0]  chip_sel;
  logic [15:0] word_addr;
  logic [7:0]  len;
  logic        busy;
  logic        no_ack;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        standby;
  logic        fill_we;
  logic [15:0] fill_addr;
  logic [7:0]  fill_data;
  logic [2:0]  strap;
  logic [7:0]  got[$];
  int          error_cnt;
  int          n_compared;
  int          cyc = 0;

  two_wire_if link_if ();

  eeprom_read_host #(.QTR_CYC(2)) i_eeprom_read_host (
    .MCLK_I(mclk), .RESET_I(reset), .REQ_I(req), .RANDOM_I(random_rd), .CHIP_SEL_I(chip_sel),
    .WORD_ADDR_I(word_addr), .LEN_I(len), .BUSY_O(busy), .NO_ACK_O(no_ack), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .link(link_if));

  eeprom_read_device i_eeprom_read_device (
    .MCLK_I(mclk), .RESET_I(reset), .CHIP_SELECT_STRAP_HI_I(strap[2]), .CHIP_SELECT_STRAP_MID_I(strap[1]),
    .CHIP_SELECT_STRAP_LO_I(strap[0]), .FILL_WE_I(fill_we), .FILL_ADDR_I(fill_addr),
    .FILL_DATA_I(fill_data), .STANDBY_O(standby), .link(link_if));

  eeprom_link_chk #(.STRAP(3'h5)) i_eeprom_link_chk (
    .MCLK_I(mclk), .RESET_I(reset), .scl(link_if.scl), .host_sda_o(link_if.host_sda_o),
    .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o), .dev_sda_oe(link_if.dev_sda_oe),
    .sda(link_if.sda));

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      got.push_back(rd_data);
    end
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d values, %0d wrong", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic fill(input logic [15:0] a, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge mclk);
      fill_we   = 1'b1;
      fill_addr = a + 16'(k);
      fill_data = pat(a + 16'(k));
    end
    @(negedge mclk);
    fill_we = 1'b0;
  endtask

  // one request, then wait for the end and judge bytes, ack status and idle link
  task automatic run(input logic rnd, input logic [2:0] cs, input logic [15:0] a, input logic [7:0] n,
                     input logic [15:0] first, input int nbytes, input logic nack);
    int   i;
    logic saw_active;
    got.delete();
    saw_active = 1'b0;
    @(negedge mclk);
    req       = 1'b1;
    random_rd = rnd;
    chip_sel  = cs;
    word_addr = a;
    len       = n;
    @(negedge mclk);
    req = 1'b0;
    i   = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge mclk);
      if (standby === 1'b0) begin
        saw_active = 1'b1;
      end
      i++;
    end
    check(16'(saw_active), 16'h0001, "standby left while addressed");
    check(16'(got.size()), 16'(nbytes), "byte count");
    for (int k = 0; k < got.size() && k < nbytes; k++) begin
      check(16'(got[k]), 16'(pat(first + 16'(k))), "read byte");
    end
    check(16'(no_ack), 16'(nack), "no ack flag");
    repeat (8) @(negedge mclk);
    check(16'(standby), 16'h0001, "standby after stop");
    check(16'(link_if.sda), 16'h0001, "data line released");
  endtask

  task automatic t_current;
    run(1'b0, 3'h5, 16'h0000, 8'h01, 16'h0000, 1, 1'b0);
    run(1'b0, 3'h5, 16'h0000, 8'h02, 16'h0001, 2, 1'b0);
    $display("current-address and sequential reads done");
  endtask

  task automatic t_random;
    run(1'b1, 3'h5, 16'h1233, 8'h01, 16'h1233, 1, 1'b0);
    run(1'b0, 3'h5, 16'h0000, 8'h01, 16'h1234, 1, 1'b0);
    $display("random read done");
  endtask

  task automatic t_wrap;
    run(1'b1, 3'h5, 16'hFFFE, 8'h04, 16'hFFFE, 4, 1'b0);
    $display("wrap across the array top done");
  endtask

  task automatic t_select;
    run(1'b0, 3'h2, 16'h0000, 8'h01, 16'h0000, 0, 1'b1);
    repeat (200) @(negedge mclk);
    // length 0 is read as one byte; the counter must survive the refusal and the idle gap
    run(1'b0, 3'h5, 16'h0000, 8'h00, 16'h0002, 1, 1'b0);
    $display("select mismatch and idle hold done");
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("wrong value at %0t: run hung", $time);
      print_verdict();
    end
  end

  initial begin
    reset      = 1'b1;
    req        = 1'b0;
    random_rd  = 1'b0;
    chip_sel   = 3'h5;
    word_addr  = 16'h0000;
    len        = 8'h01;
    fill_we    = 1'b0;
    fill_addr  = 16'h0000;
    fill_data  = 8'h00;
    strap      = 3'h5;
    error_cnt  = 0;
    n_compared = 0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    fill(16'h0000, 4);
    fill(16'h1233, 2);
    fill(16'hFFFE, 2);
    t_current();
    t_random();
    t_wrap();
    t_select();
    print_verdict();
  end
endmodule // tb

// File: two_wire_if.sv
// two-wire link between bus controller and serial memory
`timescale 1ns/100ps
interface two_wire_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open-drain wire with pull-up: any enabled low driver wins
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport dev (
    input  scl,
    output dev_sda_o,
    output dev_sda_oe,
    input  sda
  );
endinterface
